// ===== pm_bus_if.sv
/*
 SRAM-like host bus between the host end and the device end.
 Assumes both ends run on the same sys_clk; strobes last one cycle.
*/
`timescale 1ns/10ps
interface pm_bus_if;
	logic rd_stb;
	logic wr_stb;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic rd_valid;

	modport host (
		output rd_stb,
		output wr_stb,
		output addr,
		output wdata,
		input rdata,
		input rd_valid
	);

	modport device (
		input rd_stb,
		input wr_stb,
		input addr,
		input wdata,
		output rdata,
		output rd_valid
	);
endinterface

// ===== pm_cfg.svh
/*
 Offsets, field positions and timing counts of the power management control block.
 Assumes a 50 MHz sys_clk and byte offsets on an 8-bit host address.
*/
// Overview of operation
// - Host reads device once before writes work
// - States: full, wake detect, energy detect, reserved
// - Byte check write wakes reduced-power device
// - Not ready: host writes only byte check; host gates on its asleep flag, so right after reset it can write before ready
// - PHY reset bit 10 holds PHY 100us
// - PHY reset bit clears on PHY release
// - PHY reset writes ignored while bit set
// - Wake-LAN bit 9 drives enabled wake output
// - Wake-LAN event raises power event interrupt
// - Energy-detect bit 8 drives enabled wake output
// - Energy event raises power event interrupt
// - Bit 6: zero open-drain, one push-pull
// - Open-drain output always active low
// - Cause field bits 5:4 encodes event kind
// - Cause bits clear by writing one
// - Cause clear only when full power, ready
// - Cause holds while its source stays active
// - Bit 3 selects pulsed or static output
// - Pulse lasts 50 ms; static until cleared
// - Bit 2 sets push-pull polarity
// - Bit 1 gates only external wake output
// - Ready bit 0 set after stabilising
`ifndef PM_CFG_SVH
`define PM_CFG_SVH

// ********************************
// Register map
// ********************************
`define PWR_CTRL_OFF 8'h84
`define BYTE_CHECK_OFF 8'h64

// ********************************
// Field positions
// ********************************
`define PS_MSB 13
`define PS_LSB 12
`define PHY_RESET_REQUEST_BIT 10
`define WAKE_LAN_ENABLE_BIT 9
`define ENERGY_DETECT_ENABLE_BIT 8
`define DRV_TYPE_BIT 6
`define CAUSE_MSB 5
`define CAUSE_LSB 4
`define PULSE_SEL_BIT 3
`define POL_BIT 2
`define OUT_EN_BIT 1
`define READY_BIT 0

// ********************************
// Timing
// ********************************
`define CLK_MHZ 50
`define PHY_RESET_REQUEST_TIME_US 100
`define PHY_RESET_REQUEST_CYCLES (`PHY_RESET_REQUEST_TIME_US * `CLK_MHZ)
`define WAKE_PULSE_TIME_MS 50
`define WAKE_PULSE_CYCLES (`WAKE_PULSE_TIME_MS * 1000 * `CLK_MHZ)
`define READY_DELAY_CYCLES 8'h10
`define TIMER_WIDTH 22

`endif

// ===== pm_device.sv
/*
 Device end: power management control register, PHY reset timing and wake output.
 Holds the register fields, the ready settle counter and the two one-shot timers.
 Assumes the host keeps its own access order; event sources are levels on sys_clk.
 Assumes a pull-up on the wake pin while it is left in open-drain drive.
 Assumes reads of any offset are always answered, asleep or not.
*/
`timescale 1ns/10ps
`include "pm_cfg.svh"
module pm_device #(
	parameter int unsigned PHY_RESET_REQUEST_CYCLES = `PHY_RESET_REQUEST_CYCLES,
	parameter int unsigned WAKE_PULSE_CYCLES = `WAKE_PULSE_CYCLES,
	parameter logic [31:0] BYTE_CHECK_VALUE = 32'h1234ABCD // Arbitrary value
) (
	input wire logic sys_clk,
	input wire logic rst,
	pm_bus_if.device bus,
	input wire logic wol_event,
	input wire logic energy_event,
	output logic phy_reset,
	output logic power_event_interrupt,
	output logic wake_event_output,
	output logic wake_event_output_oe,
	output pm_pkg::power_state_e power_state,
	output logic device_ready
);
	import pm_pkg::*;

	// ********************************
	// State
	// ********************************
	dev_s q;
	dev_s d;
	logic wr_ctrl;
	logic wr_check;
	logic ctrl_ok;
	power_state_e ps_w;
	logic [1:0] set_v;
	logic [1:0] clr_v;
	logic phy_start;
	logic phy_done;
	logic pulse_start;
	logic pulse_busy;
	logic active;
	logic [1:0] armed;
	logic sleep_req;
	logic [31:0] ctrl_word;

	// ********************************
	// Timers
	// ********************************
	pm_timer #(.W(`TIMER_WIDTH), .CYCLES(PHY_RESET_REQUEST_CYCLES)) phy_tmr (
		.sys_clk(sys_clk),
		.rst(rst),
		.start(phy_start),
		.busy(),
		.done(phy_done)
	);

	pm_timer #(.W(`TIMER_WIDTH), .CYCLES(WAKE_PULSE_CYCLES)) pulse_tmr (
		.sys_clk(sys_clk),
		.rst(rst),
		.start(pulse_start),
		.busy(pulse_busy),
		.done()
	);

	// ********************************
	// Next state
	// ********************************
	always_comb begin
		d = q;
		d.rd_valid = 1'b0;
		wr_ctrl = bus.wr_stb && (bus.addr == `PWR_CTRL_OFF);
		wr_check = bus.wr_stb && (bus.addr == `BYTE_CHECK_OFF);
		// Control writes while not ready are dropped so a stray access cannot reconfigure
		ctrl_ok = wr_ctrl && q.ready;
		ps_w = power_state_e'(bus.wdata[`PS_MSB:`PS_LSB]);
		phy_start = 1'b0;
		ctrl_word = 32'h00000000;
		sleep_req = ctrl_ok && ps_w != full_power_state && ps_w != reserved_state;

		// ********************************
		// Power state and ready
		// ********************************
		// Settle count runs only in full power, so every wake waits the whole delay
		if (!q.ready && q.pstate == full_power_state) begin
			if (q.rdy_cnt == `READY_DELAY_CYCLES) begin
				d.ready = 1'b1;
			end else begin
				d.rdy_cnt = q.rdy_cnt + 8'h01;
			end
		end

		if (sleep_req) begin
			d.pstate = ps_w;
			d.ready = 1'b0;
			d.rdy_cnt = 8'h00;
		end
		// Any data wakes; the value written is not looked at
		if (wr_check && q.pstate != full_power_state) begin
			d.pstate = full_power_state;
			d.rdy_cnt = 8'h00;
		end

		// ********************************
		// Configuration and PHY reset
		// ********************************
		// Config fields are written whole; a zero in a bit clears it
		if (ctrl_ok) begin
			d.wake_lan_enable = bus.wdata[`WAKE_LAN_ENABLE_BIT];
			d.energy_detect_enable = bus.wdata[`ENERGY_DETECT_ENABLE_BIT];
			d.drv_type = bus.wdata[`DRV_TYPE_BIT];
			d.pulse_sel = bus.wdata[`PULSE_SEL_BIT];
			d.pol = bus.wdata[`POL_BIT];
			d.out_en = bus.wdata[`OUT_EN_BIT];
		end

		if (ctrl_ok && bus.wdata[`PHY_RESET_REQUEST_BIT] && !q.phy_reset_request) begin
			d.phy_reset_request = 1'b1;
			phy_start = 1'b1;
		end
		// Start needs the bit clear, so the hold timer never restarts early
		if (phy_done) begin
			d.phy_reset_request = 1'b0;
		end

		// ********************************
		// Wake cause
		// ********************************
		// Bit 1 is wake frame, bit 0 energy; both set reads as multiple events
		set_v = {wol_event && q.wake_lan_enable, energy_event && q.energy_detect_enable};
		clr_v = 2'h0;
		if (ctrl_ok && q.pstate == full_power_state) begin
			clr_v = bus.wdata[`CAUSE_MSB:`CAUSE_LSB];
		end
		// A source still active sets again, so set wins over clear
		d.cause = (q.cause & ~clr_v) | set_v;
		// Only a newly set cause starts a pulse; a standing one never retriggers it
		pulse_start = |(set_v & ~q.cause);

		// ********************************
		// Wake pin
		// ********************************
		armed = q.cause & {q.wake_lan_enable, q.energy_detect_enable};
		active = q.out_en && (|armed);
		if (q.pulse_sel) begin
			active = active && pulse_busy;
		end
		// Open drain only pulls low, so the polarity bit has no effect there
		if (q.drv_type) begin
			d.wake_oe = 1'b1;
			d.wake_out = q.pol ? active : !active;
		end else begin
			d.wake_oe = active;
			d.wake_out = 1'b0;
		end

		// ********************************
		// Read data
		// ********************************
		ctrl_word[`PS_MSB:`PS_LSB] = q.pstate;
		ctrl_word[`PHY_RESET_REQUEST_BIT] = q.phy_reset_request;
		ctrl_word[`WAKE_LAN_ENABLE_BIT] = q.wake_lan_enable;
		ctrl_word[`ENERGY_DETECT_ENABLE_BIT] = q.energy_detect_enable;
		ctrl_word[`DRV_TYPE_BIT] = q.drv_type;
		ctrl_word[`CAUSE_MSB:`CAUSE_LSB] = q.cause;
		ctrl_word[`PULSE_SEL_BIT] = q.pulse_sel;
		ctrl_word[`POL_BIT] = q.pol;
		ctrl_word[`OUT_EN_BIT] = q.out_en;
		ctrl_word[`READY_BIT] = q.ready;
		if (bus.rd_stb) begin
			d.rd_valid = 1'b1;
			case (bus.addr)
				`PWR_CTRL_OFF: begin
					d.rdata = ctrl_word;
				end
				`BYTE_CHECK_OFF: begin
					d.rdata = BYTE_CHECK_VALUE;
				end
				// Unmapped offsets read as zero
				default: begin
					d.rdata = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ********************************
	// Outputs
	// ********************************
	assign bus.rdata = q.rdata;
	assign bus.rd_valid = q.rd_valid;
	assign phy_reset = q.phy_reset_request;
	// Interrupt follows the cause bits, whatever the pin enable
	assign power_event_interrupt = |q.cause;
	assign wake_event_output = q.wake_out;
	assign wake_event_output_oe = q.wake_oe;
	assign power_state = q.pstate;
	assign device_ready = q.ready;
endmodule

// ===== pm_host.sv
/*
 Host end: turns user commands into bus cycles and keeps the host's access order.
 Assumes the device answers a read strobe with rd_valid one cycle later.
*/
`timescale 1ns/10ps
`include "pm_cfg.svh"
module pm_host (
	input wire logic sys_clk,
	input wire logic rst,
	pm_bus_if.host bus,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_addr,
	input wire logic [31:0] cmd_wdata,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic rsp_refused,
	output logic [31:0] rsp_data
);
	import pm_pkg::*;

	host_s q;
	host_s d;
	logic refuse;

	// ********************************
	// Issue one command
	// ********************************
	function automatic host_s issue(input host_s s);
		host_s r;
		r = s;
		r.addr = s.cmd_addr;
		r.wdata = s.cmd_wdata;
		if (s.cmd_write) begin
			r.wr_stb = 1'b1;
			r.rsp_valid = 1'b1;
			r.state = h_idle;
			if (s.cmd_addr == `PWR_CTRL_OFF &&
				s.cmd_wdata[`PS_MSB:`PS_LSB] != full_power_state) begin
				r.asleep = 1'b1;
				r.need_read = 1'b1;
			end
			if (s.cmd_addr == `BYTE_CHECK_OFF && s.asleep) begin
				r.need_read = 1'b1;
			end
		end else begin
			r.rd_stb = 1'b1;
			r.state = h_rd_wait;
		end
		return r;
	endfunction

	always_comb begin
		d = q;
		d.rd_stb = 1'b0;
		d.wr_stb = 1'b0;
		d.rsp_valid = 1'b0;
		d.rsp_refused = 1'b0;
		refuse = 1'b0;
		case (q.state)
			h_idle: begin
				if (cmd_valid) begin
					d.cmd_write = cmd_write;
					d.cmd_addr = cmd_addr;
					d.cmd_wdata = cmd_wdata;
					refuse = cmd_write && ((q.asleep && cmd_addr != `BYTE_CHECK_OFF) ||
						(cmd_addr == `PWR_CTRL_OFF &&
						cmd_wdata[`PS_MSB:`PS_LSB] == reserved_state));
					if (refuse) begin
						d.rsp_valid = 1'b1;
						d.rsp_refused = 1'b1;
					end else if (cmd_write && q.need_read) begin
						// A throwaway read of the control register, which is always readable
						d.rd_stb = 1'b1;
						d.addr = `PWR_CTRL_OFF;
						d.state = h_pre_wait;
					end else begin
						d = issue(d);
					end
				end
			end
			h_pre_wait: begin
				if (bus.rd_valid) begin
					d.need_read = 1'b0;
					if (bus.rdata[`READY_BIT]) begin
						d.asleep = 1'b0;
					end
					d = issue(d);
				end
			end
			h_rd_wait: begin
				if (bus.rd_valid) begin
					d.need_read = 1'b0;
					if (q.cmd_addr == `PWR_CTRL_OFF && bus.rdata[`READY_BIT]) begin
						d.asleep = 1'b0;
					end
					d.rsp_valid = 1'b1;
					d.rsp_data = bus.rdata;
					d.state = h_idle;
				end
			end
			default: begin
				d.state = h_idle;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '0;
			q.need_read <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign cmd_ready = (q.state == h_idle);
	assign rsp_valid = q.rsp_valid;
	assign rsp_refused = q.rsp_refused;
	assign rsp_data = q.rsp_data;
	assign bus.rd_stb = q.rd_stb;
	assign bus.wr_stb = q.wr_stb;
	assign bus.addr = q.addr;
	assign bus.wdata = q.wdata;
endmodule

// ===== pm_pkg.sv
/*
 Types shared by both ends of the power management control block.
 Assumes pm_cfg.svh for all numeric constants.
*/
package pm_pkg;

	// ********************************
	// Power states
	// ********************************
	typedef enum logic [1:0] {
		full_power_state = 2'h0,
		wake_detect_state = 2'h1,
		energy_detect_state = 2'h2,
		reserved_state = 2'h3
	} power_state_e;

	// ********************************
	// Device state
	// ********************************
	typedef struct packed {
		power_state_e pstate;
		logic ready;
		logic [7:0] rdy_cnt;
		logic phy_reset_request;
		logic wake_lan_enable;
		logic energy_detect_enable;
		logic drv_type;
		logic [1:0] cause;
		logic pulse_sel;
		logic pol;
		logic out_en;
		logic wake_out;
		logic wake_oe;
		logic [31:0] rdata;
		logic rd_valid;
	} dev_s;

	// ********************************
	// Host state
	// ********************************
	typedef enum logic [1:0] {
		h_idle = 2'h0,
		h_pre_wait = 2'h1,
		h_rd_wait = 2'h3
	} host_state_e;

	typedef struct packed {
		host_state_e state;
		logic need_read;
		logic asleep;
		logic cmd_write;
		logic [7:0] cmd_addr;
		logic [31:0] cmd_wdata;
		logic rd_stb;
		logic wr_stb;
		logic [7:0] addr;
		logic [31:0] wdata;
		logic rsp_valid;
		logic rsp_refused;
		logic [31:0] rsp_data;
	} host_s;

endpackage

// ===== pm_props.sv
/*
 Checker for the host bus and device pins of the power management block.
 Assumes one sys_clk and the synchronous active-high rst.
*/
`timescale 1ns/10ps
`include "pm_cfg.svh"
module pm_props #(
	parameter int unsigned PHY_RESET_REQUEST_CYCLES = 20
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic rd_stb,
	input wire logic wr_stb,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic rd_valid,
	input wire logic wol_event,
	input wire logic energy_event,
	input wire logic phy_reset,
	input wire logic power_event_interrupt,
	input wire pm_pkg::power_state_e power_state,
	input wire logic device_ready
);
	import pm_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ****************
	// Helpers
	// ****************
	// Counter does not restart on a retrigger, so a PHY hold that restarts shows as too long
	logic [15:0] hi_cnt_q;
	logic seen_rd_q;
	always_ff @(posedge sys_clk) begin
		hi_cnt_q <= (rst || !phy_reset) ? 16'h0 : hi_cnt_q + 16'h1;
		seen_rd_q <= rst ? 1'b0 : (seen_rd_q | rd_valid);
	end
	phy_start_a: assert property (wr_stb && addr == `PWR_CTRL_OFF && wdata[10] &&
		device_ready && !phy_reset && power_state == full_power_state |=> phy_reset)
		else $error("PHY reset not started");
	phy_hold_a: assert property ($fell(phy_reset) |-> hi_cnt_q == 16'(PHY_RESET_REQUEST_CYCLES))
		else $error("PHY reset hold length wrong");
	wake_write_a: assert property (wr_stb && addr == `BYTE_CHECK_OFF &&
		power_state != full_power_state |=> power_state == full_power_state)
		else $error("Byte check write did not wake");
	ready_full_a: assert property ($rose(device_ready) |-> power_state == full_power_state)
		else $error("Ready before full power");
	sleep_busy_a: assert property (power_state != full_power_state |-> !device_ready)
		else $error("Ready while asleep");
	host_wake_only_a: assert property (wr_stb && !device_ready |-> addr == `BYTE_CHECK_OFF)
		else $error("Write while not ready");
	read_first_a: assert property (wr_stb && addr == `PWR_CTRL_OFF |-> seen_rd_q)
		else $error("Control write before any read");
	irq_cause_a: assert property ($rose(power_event_interrupt) |->
		$past(wol_event || energy_event)) else $error("Interrupt without event");
	cover property ($fell(phy_reset));
	cover property ($rose(device_ready));
	cover property ($rose(power_event_interrupt));
endmodule

// ===== pm_timer.sv
/*
 One-shot down counter: busy for CYCLES clocks after start, done in the last one.
 Assumes start is a one-cycle pulse from logic on sys_clk.
*/
`timescale 1ns/10ps
module pm_timer #(
	parameter int W = 22,
	parameter int unsigned CYCLES = 5000
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic start,
	output logic busy,
	output logic done
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} tmr_s;

	tmr_s q;
	tmr_s d;

	always_comb begin
		d = q;
		if (start) begin
			d.cnt = W'(CYCLES);
		end else if (q.cnt != '0) begin
			d.cnt = q.cnt - W'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign busy = (q.cnt != '0);
	assign done = (q.cnt == W'(1));
endmodule

// ===== power_mgmt_control_tb.sv
/*
 Testbench joining host and device ends through the bus interface.
 Assumes pm_cfg.svh offsets and short PHY and pulse counts set here.
*/
`timescale 1ns/10ps
`include "pm_cfg.svh"
module power_mgmt_control_tb;
	import pm_pkg::*;
	typedef struct {logic rf; logic [31:0] d; logic [31:0] m;} note_s;
	logic sys_clk = 0, rst = 1, wol_event = 0, energy_event = 0, cmd_valid = 0, cmd_write = 0;
	logic [7:0] cmd_addr = 8'h00;
	logic [31:0] cmd_wdata = 32'h0, rsp_data;
	logic cmd_ready, rsp_valid, rsp_refused, phy_reset, power_event_interrupt;
	logic wake_event_output, wake_event_output_oe, device_ready;
	power_state_e power_state;
	int fails = 0, n_tests = 0, seed = 4348, k, s;
	note_s exp_q[$];
	note_s nt;
	always #10 sys_clk = ~sys_clk;
	pm_bus_if i_pm_bus_if ();
	pm_device #(.PHY_RESET_REQUEST_CYCLES(20), .WAKE_PULSE_CYCLES(50)) i_pm_device (.sys_clk(sys_clk),
		.rst(rst), .bus(i_pm_bus_if), .wol_event(wol_event), .energy_event(energy_event),
		.phy_reset(phy_reset), .power_event_interrupt(power_event_interrupt),
		.wake_event_output(wake_event_output), .wake_event_output_oe(wake_event_output_oe),
		.power_state(power_state), .device_ready(device_ready));
	pm_host i_pm_host (.sys_clk(sys_clk), .rst(rst), .bus(i_pm_bus_if), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_refused(rsp_refused), .rsp_data(rsp_data));
	pm_props #(.PHY_RESET_REQUEST_CYCLES(20)) i_pm_props (.sys_clk(sys_clk), .rst(rst),
		.rd_stb(i_pm_bus_if.rd_stb), .wr_stb(i_pm_bus_if.wr_stb), .addr(i_pm_bus_if.addr),
		.wdata(i_pm_bus_if.wdata), .rd_valid(i_pm_bus_if.rd_valid), .wol_event(wol_event),
		.energy_event(energy_event), .phy_reset(phy_reset),
		.power_event_interrupt(power_event_interrupt), .power_state(power_state),
		.device_ready(device_ready));
	// ****************
	// Tasks
	// ****************
	task automatic chk(input logic [31:0] got, input logic [31:0] ex, input logic [31:0] m);
		n_tests++;
		if ((got & m) !== (ex & m)) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, ex);
		end
	endtask
	task automatic wrap_up;
		$display("Comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// Queues the expected answer, then holds the command until accepted
	task automatic cmd(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic rf, input logic [31:0] ed, input logic [31:0] em);
		int j;
		exp_q.push_back(note_s'{rf, ed, em});
		cmd_valid = 1;
		cmd_write = w;
		cmd_addr = a;
		cmd_wdata = d;
		j = 0;
		while (cmd_ready !== 1'b1 && j < 50) begin @(posedge sys_clk); #1; j++; end
		@(posedge sys_clk);
		#1 cmd_valid = 0;
		while (exp_q.size() != 0 && j < 100) begin @(posedge sys_clk); j++; end
		#1;
		if (j >= 100) chk(0, 1, 1);
	endtask
	always @(negedge sys_clk) begin
		if (rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) chk(0, 1, 1);
			else begin
				nt = exp_q.pop_front();
				chk(32'(rsp_refused), 32'(nt.rf), 1);
				chk(rsp_data, nt.d, nt.m);
			end
		end
	end
	initial begin
		#100000;
		fails++;
		wrap_up;
	end
	// ****************
	// Scenarios
	// ****************
	initial begin
		idle(6);
		rst = 0;
		k = 0;
		while (device_ready !== 1'b1 && k < 50) begin @(posedge sys_clk); k++; end
		idle(1);
		chk(32'(phy_reset | power_event_interrupt | wake_event_output_oe), 0, 1);
		cmd(1, `PWR_CTRL_OFF, 32'h2, 0, 0, 0);
		cmd(0, `PWR_CTRL_OFF, 0, 0, 32'h3, 32'hFFFFFFFF);
		cmd(0, 8'h10, 0, 0, 0, 32'hFFFFFFFF);
		cmd(0, `BYTE_CHECK_OFF, 0, 0, 32'h1234ABCD, 32'hFFFFFFFF);
		$display("Test reset done");
		cmd(1, `PWR_CTRL_OFF, 32'h400, 0, 0, 0);
		cmd(1, `PWR_CTRL_OFF, 32'h400, 0, 0, 0);
		cmd(0, `PWR_CTRL_OFF, 0, 0, 32'h401, 32'h401);
		idle(30);
		cmd(0, `PWR_CTRL_OFF, 0, 0, 32'h1, 32'h401);
		$display("Test phy reset done");
		cmd(1, `PWR_CTRL_OFF, 32'h34E, 0, 0, 0);
		idle(2);
		chk(32'({wake_event_output_oe, wake_event_output}), 32'h2, 32'h3);
		energy_event = 1;
		idle(1);
		energy_event = 0;
		idle(2);
		chk(32'({power_event_interrupt, wake_event_output_oe, wake_event_output}), 7, 7);
		cmd(0, `PWR_CTRL_OFF, 0, 0, 32'h10, 32'h30);
		idle(60);
		chk(32'({wake_event_output_oe, wake_event_output}), 32'h2, 32'h3);
		wol_event = 1;
		idle(1);
		wol_event = 0;
		cmd(0, `PWR_CTRL_OFF, 0, 0, 32'h30, 32'h30);
		cmd(1, `PWR_CTRL_OFF, 32'h35E, 0, 0, 0);
		cmd(0, `PWR_CTRL_OFF, 0, 0, 32'h20, 32'h30);
		energy_event = 1;
		cmd(1, `PWR_CTRL_OFF, 32'h37E, 0, 0, 0);
		cmd(0, `PWR_CTRL_OFF, 0, 0, 32'h10, 32'h30);
		energy_event = 0;
		cmd(1, `PWR_CTRL_OFF, 32'h35E, 0, 0, 0);
		cmd(0, `PWR_CTRL_OFF, 0, 0, 32'h0, 32'h30);
		chk(32'(power_event_interrupt), 0, 1);
		$display("Test pulsed push-pull done");
		cmd(1, `PWR_CTRL_OFF, 32'h142, 0, 0, 0);
		idle(2);
		chk(32'({wake_event_output_oe, wake_event_output}), 32'h3, 32'h3);
		energy_event = 1;
		idle(1);
		energy_event = 0;
		idle(2);
		chk(32'({wake_event_output_oe, wake_event_output}), 32'h2, 32'h3);
		cmd(1, `PWR_CTRL_OFF, 32'h152, 0, 0, 0);
		$display("Test static push-pull active low done");
		cmd(1, `PWR_CTRL_OFF, 32'h106, 0, 0, 0);
		idle(2);
		chk(32'({wake_event_output_oe, wake_event_output}), 0, 32'h2);
		energy_event = 1;
		idle(1);
		energy_event = 0;
		idle(60);
		chk(32'({wake_event_output_oe, wake_event_output}), 32'h2, 32'h3);
		cmd(1, `PWR_CTRL_OFF, 32'h116, 0, 0, 0);
		idle(3);
		chk(32'(wake_event_output_oe), 0, 1);
		cmd(1, `PWR_CTRL_OFF, 32'h200, 0, 0, 0);
		wol_event = 1;
		idle(1);
		wol_event = 0;
		idle(2);
		chk(32'({power_event_interrupt, wake_event_output_oe}), 32'h2, 32'h3);
		cmd(1, `PWR_CTRL_OFF, 32'h220, 0, 0, 0);
		$display("Test static open-drain done");
		cmd(1, `PWR_CTRL_OFF, 32'h3000, 1, 0, 0);
		for (s = 1; s < 3; s++) begin
			cmd(1, `PWR_CTRL_OFF, 32'(s << 12), 0, 0, 0);
			cmd(0, `PWR_CTRL_OFF, 0, 0, 32'(s << 12), 32'h3001);
			cmd(1, `PWR_CTRL_OFF, 32'h2, 1, 0, 0);
			cmd(1, `BYTE_CHECK_OFF, 32'($random(seed)), 0, 0, 0);
			idle(25);
			cmd(0, `PWR_CTRL_OFF, 0, 0, 32'h1, 32'h3001);
		end
		$display("Test sleep and wake done");
		wrap_up;
	end
endmodule
